// ==== inc/diag_chop_pkg.sv ====
// Package with register map, field layout, reset values and carrier types of the diag/chop bank.
package diag_chop_pkg;

  // Printed register offsets are kept as word indices; the byte address is four times the index.
  localparam logic [9:0] DIAG_SELECT_INDEX = 10'h057;
  localparam logic [9:0] DELAY_CLOCK_INDEX = 10'h058;
  localparam logic [9:0] CHOP_RATE_INDEX = 10'h059;
  localparam int ADDR_WIDTH = 12;

  // Values after reset.
  localparam logic [7:0] DIAG_SELECT_RESET = 8'h00;
  localparam logic [7:0] DELAY_CLOCK_RESET = 8'h02;
  localparam logic [7:0] CHOP_RATE_RESET = 8'h0a;

  // Writable bit masks; all other bit positions read as zero.
  localparam logic [7:0] DIAG_SELECT_MASK = 8'h77;
  localparam logic [7:0] DELAY_CLOCK_MASK = 8'h0f;
  localparam logic [7:0] CHOP_RATE_MASK = 8'h0f;

  // Field positions.
  localparam int FIRST_CHECK_LSB = 0;
  localparam int SECOND_CHECK_LSB = 4;
  localparam int DELAY_ENABLE_LSB = 2;
  localparam int FIRST_CHOP_LSB = 2;
  localparam int SECOND_CHOP_LSB = 0;

  // Check selection codes.
  localparam logic [2:0] CODE_OFF = 3'h0;
  localparam logic [2:0] CODE_POS_FULL = 3'h3;
  localparam logic [2:0] CODE_NEG_FULL = 3'h4;
  localparam logic [2:0] CODE_ZERO = 3'h5;

  // Chop rate codes and half periods counted in sampler clock ticks.
  localparam logic [1:0] CHOP_DIV8 = 2'h1;
  localparam logic [1:0] CHOP_DIV32 = 2'h2;
  localparam logic [4:0] HALF_DIV8 = 5'h04;
  localparam logic [4:0] HALF_DIV32 = 5'h10;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {CHECK_OFF, CHECK_POS_FULL, CHECK_NEG_FULL, CHECK_ZERO} check_type;

  // Per-channel control handed to the analog front end.
  typedef struct packed {
    check_type check;
    logic delayed_clock_en;
  } chan_ctrl_type;

  // Whole state of the register bank.
  typedef struct packed {
    logic [7:0] diag_check_voltage_select;
    logic [7:0] delayed_mod_clock_control;
    logic [7:0] chop_rate_control;
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [ADDR_WIDTH-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    chan_ctrl_type [3:0] chan_ctrl;
  } bank_state_type;

  // State of one chop phase generator.
  typedef struct packed {
    logic [4:0] count;
    logic phase;
  } chop_state_type;

endpackage

// ==== rtl/chop_phase_gen.sv ====
// Chop phase generator that toggles at the rate chosen by a two-bit chop rate field.
`timescale 1ns/1ps
`default_nettype none

module chop_phase_gen (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Sampler clock tick and rate selection.
  input wire logic sampler_tick,
  input wire logic [1:0] rate,
  // Chop phase.
  output logic chop_phase
);

  diag_chop_pkg::chop_state_type state_reg;
  diag_chop_pkg::chop_state_type state_next;
  logic [4:0] half;

  // Half period follows the field; an undefined code parks the phase low.
  always_comb begin
    state_next = state_reg;
    half = 5'h00;
    case (rate)
      diag_chop_pkg::CHOP_DIV8: half = diag_chop_pkg::HALF_DIV8;
      diag_chop_pkg::CHOP_DIV32: half = diag_chop_pkg::HALF_DIV32;
      default: half = 5'h00;
    endcase
    if (half == 5'h00) begin
      state_next.count = 5'h00;
      state_next.phase = 1'b0;
    end else if (sampler_tick) begin
      if (state_reg.count >= half - 5'h01) begin
        state_next.count = 5'h00;
        state_next.phase = ~state_reg.phase;
      end else begin
        state_next.count = state_reg.count + 5'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign chop_phase = state_reg.phase;

endmodule

`default_nettype wire

// ==== rtl/diag_chop_regs.sv ====
// AXI4-Lite register bank for diagnostic check selection, delayed sampler clock and chopping.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - The check select register resets to zero so both groups start with no check voltage.
// - First group selection sits in bits 2:0 and second group selection in bits 6:4.
// - Selection code 000 is off, 011 positive full scale, 100 negative full scale, 101 zero scale.
// - Channels in the first mode group take the first selection, the others the second.
// - The delayed clock register resets to 0x02, leaving the delayed clock off everywhere.
// - Field 3:2 gives 00 none, 01 channels 0 and 1, 10 channels 2 and 3, 11 all channels.
// - The chop register resets to 0x0A with first group rate in 3:2 and second in 1:0.
// - A chop rate of 01 chops at the sampler clock over 8, 10 at the sampler clock over 32.
// - A channel gets the check voltage only while its own receive-enable bit is set.
module diag_chop_regs (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic awvalid,
  output logic awready,
  input wire logic [diag_chop_pkg::ADDR_WIDTH-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read.
  input wire logic arvalid,
  output logic arready,
  input wire logic [diag_chop_pkg::ADDR_WIDTH-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Channel setup held in registers outside this bank, and the sampler clock tick.
  input wire logic [3:0] chan_diag_receive,
  input wire logic [3:0] chan_second_group,
  input wire logic sampler_tick,
  // Controls to the channels.
  output diag_chop_pkg::chan_ctrl_type [3:0] chan_ctrl,
  output logic first_group_chop_phase,
  output logic second_group_chop_phase
);

  diag_chop_pkg::bank_state_type state_reg;
  diag_chop_pkg::bank_state_type state_next;
  // Write channel contents as seen this cycle, whether held from before or arriving now.
  logic aw_have;
  logic w_have;
  logic [diag_chop_pkg::ADDR_WIDTH-1:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic [2:0] sel;
  logic ar_hit;

  // Maps a three-bit selection onto a check; unlisted codes fall back to off.
  function automatic diag_chop_pkg::check_type decode_check(input logic [2:0] code);
    case (code)
      diag_chop_pkg::CODE_POS_FULL: decode_check = diag_chop_pkg::CHECK_POS_FULL;
      diag_chop_pkg::CODE_NEG_FULL: decode_check = diag_chop_pkg::CHECK_NEG_FULL;
      diag_chop_pkg::CODE_ZERO: decode_check = diag_chop_pkg::CHECK_ZERO;
      default: decode_check = diag_chop_pkg::CHECK_OFF;
    endcase
  endfunction

  // Word index of a byte address; the low two bits are ignored.
  function automatic logic [9:0] word_index(input logic [diag_chop_pkg::ADDR_WIDTH-1:0] addr);
    word_index = addr[diag_chop_pkg::ADDR_WIDTH-1:2];
  endfunction

  // Register bank, bus handshakes and channel control decode in one pass.
  always_comb begin
    state_next = state_reg;
    aw_have = state_reg.aw_held | (awvalid & state_reg.awready);
    w_have = state_reg.w_held | (wvalid & state_reg.wready);
    wr_addr = state_reg.aw_held ? state_reg.aw_addr : awaddr;
    wr_byte = state_reg.w_held ? state_reg.w_byte : wdata[7:0];
    wr_lane = state_reg.w_held ? state_reg.w_lane : wstrb[0];
    sel = 3'h0;
    ar_hit = 1'b0;

    // Responses retire on their own handshake.
    if (state_reg.bvalid && bready) begin
      state_next.bvalid = 1'b0;
    end
    if (state_reg.rvalid && rready) begin
      state_next.rvalid = 1'b0;
    end

    // Address and data are taken in either order and held until both are present.
    if (awvalid && state_reg.awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = awaddr;
    end
    if (wvalid && state_reg.wready) begin
      state_next.w_held = 1'b1;
      state_next.w_byte = wdata[7:0];
      state_next.w_lane = wstrb[0];
    end

    // Write commit; only byte lane 0 carries register data, so other lanes are dropped.
    // A write to an unmapped word still answers, with an error, so the master never hangs.
    if (aw_have && w_have && !state_reg.bvalid) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = diag_chop_pkg::RESP_OKAY;
      case (word_index(wr_addr))
        diag_chop_pkg::DIAG_SELECT_INDEX: begin
          if (wr_lane) begin
            state_next.diag_check_voltage_select = wr_byte & diag_chop_pkg::DIAG_SELECT_MASK;
          end
        end
        diag_chop_pkg::DELAY_CLOCK_INDEX: begin
          if (wr_lane) begin
            state_next.delayed_mod_clock_control = wr_byte & diag_chop_pkg::DELAY_CLOCK_MASK;
          end
        end
        diag_chop_pkg::CHOP_RATE_INDEX: begin
          if (wr_lane) begin
            state_next.chop_rate_control = wr_byte & diag_chop_pkg::CHOP_RATE_MASK;
          end
        end
        default: state_next.bresp = diag_chop_pkg::RESP_SLVERR;
      endcase
    end
    // Readiness comes from the next state so the readies stay registered outputs;
    // and a new write can be taken in the cycle right after each response, with no idle cycle.
    state_next.awready = !state_next.aw_held && !state_next.bvalid;
    state_next.wready = !state_next.w_held && !state_next.bvalid;

    // Read returns the stored fields with unused bits as zero; unmapped reads answer an error.
    if (arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = 32'h0000_0000;
      ar_hit = 1'b1;
      case (word_index(araddr))
        diag_chop_pkg::DIAG_SELECT_INDEX: state_next.rdata[7:0] = state_reg.diag_check_voltage_select;
        diag_chop_pkg::DELAY_CLOCK_INDEX: state_next.rdata[7:0] = state_reg.delayed_mod_clock_control;
        diag_chop_pkg::CHOP_RATE_INDEX: state_next.rdata[7:0] = state_reg.chop_rate_control;
        default: ar_hit = 1'b0;
      endcase
      state_next.rresp = ar_hit ? diag_chop_pkg::RESP_OKAY : diag_chop_pkg::RESP_SLVERR;
    end
    // Only one read is in flight, so the address channel waits until the data are taken.
    state_next.arready = !state_next.rvalid;

    // Per-channel controls are rebuilt every cycle from the stored fields.
    for (int ch = 0; ch < 4; ch++) begin
      if (chan_second_group[ch]) begin
        sel = state_reg.diag_check_voltage_select[diag_chop_pkg::SECOND_CHECK_LSB +: 3];
      end else begin
        sel = state_reg.diag_check_voltage_select[diag_chop_pkg::FIRST_CHECK_LSB +: 3];
      end
      // A channel not enabled to receive stays off whatever the selection says.
      state_next.chan_ctrl[ch].check =
        chan_diag_receive[ch] ? decode_check(sel) : diag_chop_pkg::CHECK_OFF;
      // The delayed clock enables pair channels 0 and 1 against channels 2 and 3.
      case (state_reg.delayed_mod_clock_control[diag_chop_pkg::DELAY_ENABLE_LSB +: 2])
        2'h1: state_next.chan_ctrl[ch].delayed_clock_en = (ch < 2);
        2'h2: state_next.chan_ctrl[ch].delayed_clock_en = (ch >= 2);
        2'h3: state_next.chan_ctrl[ch].delayed_clock_en = 1'b1;
        default: state_next.chan_ctrl[ch].delayed_clock_en = 1'b0;
      endcase
    end
  end

  // State register with documented reset values.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Clearing the whole struct first leaves every handshake and channel control idle.
      state_reg <= '0;
      state_reg.diag_check_voltage_select <= diag_chop_pkg::DIAG_SELECT_RESET;
      state_reg.delayed_mod_clock_control <= diag_chop_pkg::DELAY_CLOCK_RESET;
      state_reg.chop_rate_control <= diag_chop_pkg::CHOP_RATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Each group has its own divider, so a rate change in one never disturbs the other.
  // First group chop phase.
  chop_phase_gen first_chop (
    .aclk(aclk),
    .aresetn(aresetn),
    .sampler_tick(sampler_tick),
    .rate(state_reg.chop_rate_control[diag_chop_pkg::FIRST_CHOP_LSB +: 2]),
    .chop_phase(first_group_chop_phase)
  );

  // Second group chop phase.
  chop_phase_gen second_chop (
    .aclk(aclk),
    .aresetn(aresetn),
    .sampler_tick(sampler_tick),
    .rate(state_reg.chop_rate_control[diag_chop_pkg::SECOND_CHOP_LSB +: 2]),
    .chop_phase(second_group_chop_phase)
  );

  // Bus outputs come straight from the state register.
  assign awready = state_reg.awready;
  assign wready = state_reg.wready;
  assign bvalid = state_reg.bvalid;
  assign bresp = state_reg.bresp;
  assign arready = state_reg.arready;
  assign rvalid = state_reg.rvalid;
  assign rdata = state_reg.rdata;
  assign rresp = state_reg.rresp;
  assign chan_ctrl = state_reg.chan_ctrl;

endmodule

`default_nettype wire

// ==== tb/diag_chop_regs_asserts.sv ====
// Port-level checks for the diagnostic and chop register bank.
`timescale 1ns/1ps
`default_nettype none
module diag_chop_regs_asserts (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus.
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Channel side.
  input wire logic [3:0] chan_diag_receive,
  input wire logic sampler_tick,
  input wire diag_chop_pkg::chan_ctrl_type [3:0] chan_ctrl,
  input wire logic first_group_chop_phase
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address and data are offered together by our master, so both land on one edge.
  wire logic wr_take = awvalid && awready && wvalid && wready;
  wire logic mapped = awaddr[11:2] inside {diag_chop_pkg::DIAG_SELECT_INDEX,
      diag_chop_pkg::DELAY_CLOCK_INDEX, diag_chop_pkg::CHOP_RATE_INDEX};
  a_reset_clear: assert property ($rose(aresetn) |-> !bvalid && !rvalid && chan_ctrl == 12'h000)
    else $error("outputs not cleared by reset");
  a_write_answer: assert property (wr_take |=> bvalid && bresp == ($past(mapped) ?
      diag_chop_pkg::RESP_OKAY : diag_chop_pkg::RESP_SLVERR))
    else $error("write response wrong or late");
  a_resp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_busy_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_read_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("unused read bits not zero");
  a_delay_pairs: assert property (chan_ctrl[0].delayed_clock_en == chan_ctrl[1].delayed_clock_en
      && chan_ctrl[2].delayed_clock_en == chan_ctrl[3].delayed_clock_en)
    else $error("delayed clock enable pairs differ");
  a_recv_gate: assert property (chan_ctrl[0].check != diag_chop_pkg::CHECK_OFF
      |-> $past(chan_diag_receive[0]))
    else $error("check voltage on a channel not receiving");
  a_chop_on_tick: assert property ($changed(first_group_chop_phase) |-> $past(sampler_tick))
    else $error("chop phase moved without a tick");
  c_bad_write: cover property (wr_take && !mapped);
  c_zero_check: cover property (chan_ctrl[2].check == diag_chop_pkg::CHECK_ZERO);
  c_chop_rise: cover property ($rose(first_group_chop_phase));
endmodule
bind diag_chop_regs diag_chop_regs_asserts chk_u (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .chan_diag_receive(chan_diag_receive),
  .sampler_tick(sampler_tick), .chan_ctrl(chan_ctrl),
  .first_group_chop_phase(first_group_chop_phase));
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the diagnostic and chop register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic sampler_tick = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] chan_diag_receive = 4'hf, chan_second_group = 4'ha;
  logic awready, wready, bvalid, arready, rvalid;
  logic first_group_chop_phase, second_group_chop_phase;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  diag_chop_pkg::chan_ctrl_type [3:0] chan_ctrl;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  localparam logic [11:0] sel_addr = {diag_chop_pkg::DIAG_SELECT_INDEX, 2'b00};
  localparam logic [11:0] dly_addr = {diag_chop_pkg::DELAY_CLOCK_INDEX, 2'b00};
  localparam logic [11:0] chop_addr = {diag_chop_pkg::CHOP_RATE_INDEX, 2'b00};
  localparam logic [1:0] okay = 2'h0;

  // Protection and strobes are tied: the bank ignores protection and we write whole words.
  diag_chop_regs dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .chan_diag_receive(chan_diag_receive),
    .chan_second_group(chan_second_group), .sampler_tick(sampler_tick),
    .chan_ctrl(chan_ctrl), .first_group_chop_phase(first_group_chop_phase),
    .second_group_chop_phase(second_group_chop_phase));

  // Clock of 8 ns period.
  always #4 aclk = ~aclk;

  // A hang is cut short well above the fewer than two hundred cycles the run needs.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One register write; each channel is released at the edge that takes it.
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // The loop tests after each edge, once the requests driven above are visible.
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        `CHK(bresp, er)
        bready <= 1'b0;
      end
    end while (awvalid || wvalid || bready);
  endtask

  // One register read, judged against the expected byte and response.
  task automatic axi_read(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        `CHK(rdata, {24'h000000, ed})
        `CHK(rresp, er)
        rready <= 1'b0;
      end
    end while (arvalid || rready);
  endtask

  function automatic diag_chop_pkg::check_type exp_check(input logic rx, input logic [2:0] c);
    if (!rx) return diag_chop_pkg::CHECK_OFF;
    case (c)
      3'h3: return diag_chop_pkg::CHECK_POS_FULL;
      3'h4: return diag_chop_pkg::CHECK_NEG_FULL;
      3'h5: return diag_chop_pkg::CHECK_ZERO;
      default: return diag_chop_pkg::CHECK_OFF;
    endcase
  endfunction

  task automatic check_reset();
    axi_read(sel_addr, 8'h00, okay);
    axi_read(dly_addr, 8'h02, okay);
    axi_read(chop_addr, 8'h0a, okay);
    `CHK(chan_ctrl, 12'h000)
  endtask

  // Unused bits must drop out, and an unmapped word refuses with data zero.
  task automatic check_masks();
    axi_write(sel_addr, 8'hff, okay);
    axi_read(sel_addr, 8'h77, okay);
    axi_write(chop_addr, 8'hff, okay);
    axi_read(chop_addr, 8'h0f, okay);
    axi_write(12'h000, 8'h55, 2'h2);
    axi_read(12'h000, 8'h00, 2'h2);
  endtask

  // Every code on both groups; one pass runs with two channels not receiving.
  task automatic check_select();
    logic [2:0] ca, cb;
    diag_chop_pkg::check_type ec;
    for (int c = 0; c < 8; c++) begin
      ca = c[2:0];
      cb = 3'h7 - ca;
      chan_diag_receive <= (c == 3) ? 4'h6 : 4'hf;
      axi_write(sel_addr, {1'b0, cb, 1'b0, ca}, okay);
      @(negedge aclk);
      for (int k = 0; k < 4; k++) begin
        ec = exp_check(chan_diag_receive[k], chan_second_group[k] ? cb : ca);
        `CHK(chan_ctrl[k].check, ec)
      end
      // Step back onto a rising edge so the next request is launched there.
      @(posedge aclk);
    end
  endtask

  task automatic check_delay();
    for (int e = 0; e < 4; e++) begin
      axi_write(dly_addr, {4'h0, e[1:0], 2'b10}, okay);
      axi_read(dly_addr, {4'h0, e[1:0], 2'b10}, okay);
      `CHK(chan_ctrl[1].delayed_clock_en, e[0])
      `CHK(chan_ctrl[2].delayed_clock_en, e[1])
    end
  endtask

  // Code 00 clears the dividers, so 64 ticks give exactly 16 and 4 toggles.
  task automatic check_chop();
    int na, nb;
    logic pa, pb;
    na = 0;
    nb = 0;
    axi_write(chop_addr, 8'h00, okay);
    axi_write(chop_addr, 8'h06, okay);
    pa = first_group_chop_phase;
    pb = second_group_chop_phase;
    `CHK(pa, 1'b0)
    sampler_tick <= 1'b1;
    for (int i = 0; i < 70; i++) begin
      @(posedge aclk);
      if (i == 63) sampler_tick <= 1'b0;
      if (first_group_chop_phase !== pa) na++;
      if (second_group_chop_phase !== pb) nb++;
      pa = first_group_chop_phase;
      pb = second_group_chop_phase;
    end
    `CHK(na, 16)
    `CHK(nb, 4)
  endtask

  // Main sequence after five cycles of reset.
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_reset();
    check_masks();
    check_select();
    check_delay();
    check_chop();
    stop_test();
  end
endmodule
`default_nettype wire
